// *** shared/sram_pkg.sv ***
// Shared constants, types and helper functions for the burst SRAM core.
package sram_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W        = 18;
  localparam int WIDE_ADDR_W   = 17;
  localparam int NARROW_ADDR_W = 18;
  localparam int LANE_W        = 9;
  localparam int LANES         = 4;
  localparam int DATA_W        = 36;
  localparam int BURST_W       = 2;

  localparam logic [3:0] WIDE_LANE_MASK   = 4'hF;
  localparam logic [3:0] NARROW_LANE_MASK = 4'h3;
  localparam logic [3:0] NO_LANES         = 4'h0;

  // ----------------------------------------------------------------------
  // Burst counter and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  BURST_START = 2'h0;
  localparam logic [1:0]  BURST_STEP  = 2'h1;
  localparam logic [17:0] ADDR_RESET  = 18'h00000;
  localparam logic [35:0] DATA_RESET  = 36'h000000000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;

  typedef struct packed {
    logic [17:0] addr;
    logic [35:0] data;
    logic        chip_n;
    logic        expand_n;
    logic        expand_hi;
    logic        proc_strobe_n;
    logic        ctrl_strobe_n;
    logic        advance_n;
    logic [3:0]  lane_write_n;
    logic        byte_gate_n;
    logic        all_lanes_n;
  } pins_t;

  localparam pins_t PINS_IDLE = '{addr: ADDR_RESET, data: DATA_RESET, chip_n: 1'h1, expand_n: 1'h1,
                                  expand_hi: 1'h0, proc_strobe_n: 1'h1, ctrl_strobe_n: 1'h1,
                                  advance_n: 1'h1, lane_write_n: 4'hF, byte_gate_n: 1'h1,
                                  all_lanes_n: 1'h1};

  // ----------------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------------
  function automatic logic chip_selected(input logic chip_n, input logic expand_n, input logic expand_hi);
    return !chip_n && !expand_n && expand_hi;
  endfunction : chip_selected

  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt, input logic interleave);
    return interleave ? (start ^ cnt) : 2'(start + cnt);
  endfunction : burst_low

endpackage : sram_pkg

// *** shared/mem_if.sv ***
// Carrier between the access controller and the storage array.
`timescale 1ns/1ps
interface mem_if;
  logic [17:0] addr;
  logic [35:0] wdata;
  logic [3:0]  lane_we;
  logic        rd_en;
  logic [35:0] rdata;

  modport ctrl  (output addr, output wdata, output lane_we, output rd_en, input rdata);
  modport store (input addr, input wdata, input lane_we, input rd_en, output rdata);
endinterface : mem_if

// *** src/sram_array.sv ***
// Storage array with byte-lane writes and a registered read port.
`timescale 1ns/1ps
module sram_array #(
  parameter bit NARROW = 1'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  mem_if.store     port
);

  localparam int AW    = NARROW ? sram_pkg::NARROW_ADDR_W : sram_pkg::WIDE_ADDR_W;
  localparam int LN    = NARROW ? 2 : sram_pkg::LANES;
  localparam int W     = LN * sram_pkg::LANE_W;
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [35:0] rdata;
  } state_t;

  state_t      st_reg;
  state_t      st_next;
  logic [W-1:0] mem [0:DEPTH-1];

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (port.rd_en) begin
      st_next.rdata = 36'(mem[port.addr[AW-1:0]]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{rdata: sram_pkg::DATA_RESET};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign port.rdata = st_reg.rdata;

  // ----------------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------------
  // Writes finish within the edge; no external write pulse timing is needed.
  always_ff @(posedge clk) begin
    if (clk_en) begin
      for (int i = 0; i < LN; i++) begin
        if (port.lane_we[i]) begin
          mem[port.addr[AW-1:0]][i*sram_pkg::LANE_W +: sram_pkg::LANE_W] <=
            port.wdata[i*sram_pkg::LANE_W +: sram_pkg::LANE_W]; // R7
        end
      end
    end
  end

endmodule : sram_array

// *** src/sram_burst_core.sv ***
// Pipelined synchronous burst SRAM core: input registers, burst logic, output register.
// ------------------------------------------------------------------------
// Operation
// [R1] Register all synchronous inputs on rising clock.
// [R2] Two-bit counter generates burst beat addresses.
// [R3] Address loads only on either address strobe.
// [R4] Burst advances only when advance input commands.
// [R5] Write registers address, data, controls together.
// [R6] A write updates one to four lanes.
// [R7] Each lane strobe writes only its lane.
// [R8] Lane strobes act only with gate low.
// [R9] Global write low writes every lane.
// [R10] Narrow configuration has only lanes zero, one.
// [R11] Output enable gates drivers asynchronously.
// [R12] Order select picks interleaved or linear burst.
// [R13] Bus released one cycle after deselect.
// [R14] Three chip enables; primary gates processor strobe.
// [R15] Array holds 128K x 36 or 256K x 18.
// [R16] Processor strobe with chip enable starts read.
// [R17] Controller strobe selects or deselects, reads/writes.
// [R18] Advance high holds counter, waits at address.
// [R19] High enable active high, others active low.
// [R20] Counter wraps in aligned group of four.
// [R21] Read data passes through an output register.
// ------------------------------------------------------------------------
`timescale 1ns/1ps
module sram_burst_core #(
  parameter bit NARROW = 1'h0
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CLK_EN,
  input  wire logic [17:0] ADDR,
  input  wire logic [35:0] DATA_IN,
  output logic      [35:0] DATA_OUT,
  output logic             DATA_OE,
  input  wire logic        CHIP_EN_N,
  input  wire logic        EXPAND_SELECT_N,
  input  wire logic        EXPAND_SELECT_HI,
  input  wire logic        PROC_ADDR_STROBE_N,
  input  wire logic        CTRL_ADDR_STROBE_N,
  input  wire logic        BURST_ADVANCE_N,
  input  wire logic        LANE0_WRITE_N,
  input  wire logic        LANE1_WRITE_N,
  input  wire logic        LANE2_WRITE_N,
  input  wire logic        LANE3_WRITE_N,
  input  wire logic        BYTE_WRITE_GATE_N,
  input  wire logic        ALL_LANES_WRITE_N,
  input  wire logic        OUT_EN_N,
  input  wire logic        BURST_INTERLEAVE
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    sram_pkg::pins_t smp;
    logic            order_s1;
    logic            order_s2;
    logic            active;
    logic [17:0]     base;
    logic [1:0]      cnt;
    logic            rd_q;
    logic            drive;
    logic [35:0]     dout;
  } state_t;

  localparam state_t STATE_RESET = '{smp: sram_pkg::PINS_IDLE, order_s1: 1'h0, order_s2: 1'h0,
                                     active: 1'h0, base: sram_pkg::ADDR_RESET,
                                     cnt: sram_pkg::BURST_START, rd_q: 1'h0, drive: 1'h0,
                                     dout: sram_pkg::DATA_RESET};

  localparam logic [3:0] PRESENT = NARROW ? sram_pkg::NARROW_LANE_MASK : sram_pkg::WIDE_LANE_MASK;

  state_t           st_reg;
  state_t           st_next;
  sram_pkg::op_t    op;
  logic             sel;
  logic             proc_load;
  logic             load;
  logic [3:0]       wr_lanes;
  logic [17:0]      acc_addr;

  mem_if m ();

  sram_array #(
    .NARROW (NARROW)
  ) u_array (
    .clk    (CLK),
    .rst    (RST),
    .clk_en (CLK_EN),
    .port   (m.store)
  ); // R15

  // ----------------------------------------------------------------------
  // Decode of the registered inputs
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    st_next.smp = '{addr: ADDR, data: DATA_IN, chip_n: CHIP_EN_N, expand_n: EXPAND_SELECT_N,
                    expand_hi: EXPAND_SELECT_HI, proc_strobe_n: PROC_ADDR_STROBE_N,
                    ctrl_strobe_n: CTRL_ADDR_STROBE_N, advance_n: BURST_ADVANCE_N,
                    lane_write_n: {LANE3_WRITE_N, LANE2_WRITE_N, LANE1_WRITE_N, LANE0_WRITE_N},
                    byte_gate_n: BYTE_WRITE_GATE_N, all_lanes_n: ALL_LANES_WRITE_N}; // R1

    // The order pin is static in practice, but it is still synchronised before use.
    st_next.order_s1 = BURST_INTERLEAVE;
    st_next.order_s2 = st_reg.order_s1;

    sel = sram_pkg::chip_selected(st_reg.smp.chip_n, st_reg.smp.expand_n, st_reg.smp.expand_hi); // R19
    proc_load = !st_reg.smp.proc_strobe_n && !st_reg.smp.chip_n; // R14
    load = proc_load || !st_reg.smp.ctrl_strobe_n; // R3

    if (!st_reg.smp.all_lanes_n) begin
      wr_lanes = PRESENT; // R9
    end else if (!st_reg.smp.byte_gate_n) begin
      wr_lanes = ~st_reg.smp.lane_write_n & PRESENT; // R6 R8 R10
    end else begin
      wr_lanes = sram_pkg::NO_LANES; // R8
    end

    op = sram_pkg::OP_IDLE;
    if (load) begin
      st_next.active = sel; // R17
      if (sel) begin
        st_next.base = st_reg.smp.addr;
        st_next.cnt  = sram_pkg::BURST_START;
        if (proc_load) begin
          op = sram_pkg::OP_READ; // R16
        end else if (wr_lanes != sram_pkg::NO_LANES) begin
          op = sram_pkg::OP_WRITE; // R17
        end else begin
          op = sram_pkg::OP_READ;
        end
      end
    end else if (st_reg.active) begin
      if (!st_reg.smp.advance_n) begin
        st_next.cnt = 2'(st_reg.cnt + sram_pkg::BURST_STEP); // R2 R4
      end
      op = (wr_lanes != sram_pkg::NO_LANES) ? sram_pkg::OP_WRITE : sram_pkg::OP_READ; // R18
    end

    // Only the two lowest bits follow the counter, so a burst stays in its group of four.
    acc_addr = {st_next.base[17:2],
                sram_pkg::burst_low(st_next.base[1:0], st_next.cnt, st_reg.order_s2)}; // R12 R20

    st_next.rd_q  = (op == sram_pkg::OP_READ);
    st_next.drive = st_reg.rd_q; // R13
    if (st_reg.rd_q) begin
      st_next.dout = m.rdata; // R21
    end
  end

  // ----------------------------------------------------------------------
  // Array request
  // ----------------------------------------------------------------------
  assign m.addr    = acc_addr;
  assign m.wdata   = st_reg.smp.data; // R5
  assign m.lane_we = (op == sram_pkg::OP_WRITE) ? wr_lanes : sram_pkg::NO_LANES; // R5 R7
  assign m.rd_en   = (op == sram_pkg::OP_READ);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= STATE_RESET;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  assign DATA_OUT = st_reg.dout;
  // The enable must not wait for a clock edge, so it is the one output with a gate after the flop.
  assign DATA_OE  = st_reg.drive && !OUT_EN_N; // R11

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_sample_inputs: assert property (CLK_EN |=> st_reg.smp.addr == $past(ADDR)
                                              && st_reg.smp.data == $past(DATA_IN)) // R1
    else $error("Inputs not registered on the clock edge.");

  a_counter_step: assert property (CLK_EN && !load && st_reg.active && !st_reg.smp.advance_n
                                   |=> st_reg.cnt == 2'($past(st_reg.cnt) + 2'h1)) // R2
    else $error("Burst counter did not advance by one.");

  a_load_strobe: assert property (CLK_EN && !load |=> st_reg.base == $past(st_reg.base)) // R3
    else $error("Address loaded without a strobe.");

  a_wait_hold: assert property (CLK_EN && !load && st_reg.smp.advance_n
                                |=> $stable(st_reg.cnt)) // R18
    else $error("Counter moved during a wait cycle.");

  a_gate_lanes: assert property (m.lane_we != 4'h0
                                 |-> !st_reg.smp.all_lanes_n || !st_reg.smp.byte_gate_n) // R8
    else $error("Lane write without gate or global write.");

  a_global_write: assert property (op == sram_pkg::OP_WRITE && !st_reg.smp.all_lanes_n
                                   |-> m.lane_we == PRESENT) // R9
    else $error("Global write missed a lane.");

  a_lane_own: assert property (op == sram_pkg::OP_WRITE && st_reg.smp.all_lanes_n
                               |-> m.lane_we == (~st_reg.smp.lane_write_n & PRESENT)) // R7
    else $error("Lane strobe wrote the wrong lane.");

  a_narrow_lanes: assert property ((m.lane_we & ~PRESENT) == 4'h0) // R10
    else $error("Absent lane written.");

  a_proc_read: assert property (proc_load && sel |-> op == sram_pkg::OP_READ && m.lane_we == 4'h0) // R16
    else $error("Processor strobe did not start a read.");

  a_read_latency: assert property ((CLK_EN && op == sram_pkg::OP_READ) ##1 CLK_EN
                                   |=> st_reg.drive && DATA_OUT == $past(m.rdata)) // R21
    else $error("Read data not on the bus two edges later.");

  a_deselect_release: assert property ((CLK_EN && load && !sel) ##1 CLK_EN |=> !DATA_OE) // R13
    else $error("Bus still driven after deselect.");

  a_oe_block: assert property (OUT_EN_N |-> !DATA_OE) // R11
    else $error("Drivers on with output enable high.");

  c_burst_read: cover property ((CLK_EN && proc_load && sel) ##1 (CLK_EN && !st_reg.smp.advance_n)[*3]);
  c_write: cover property (op == sram_pkg::OP_WRITE && m.lane_we == 4'h1);
  c_deselect: cover property (st_reg.drive ##1 !st_reg.drive);
  c_wait: cover property (st_reg.active && st_reg.smp.advance_n && !load);

endmodule : sram_burst_core

// *** verification/sram_host_model.sv ***
// Bus master model that drives the core pins and predicts every read result.
`timescale 1ns/1ps
module sram_host_model (
  input  wire logic       clk,
  input  wire logic       ilv,
  output sram_pkg::pins_t pins
);
  // ----------------------------------------------------------------------
  // Prediction state
  // ----------------------------------------------------------------------
  logic [35:0] mem [int];
  logic [35:0] exp_q [$];
  logic        act  = 1'h0;
  logic [17:0] base = 18'h00000;
  logic [1:0]  cnt  = 2'h0;

  initial pins = sram_pkg::PINS_IDLE;

  // ----------------------------------------------------------------------
  // Pin cycles
  // ----------------------------------------------------------------------
  function automatic sram_pkg::pins_t sel_pins(input logic [17:0] a);
    sram_pkg::pins_t n;
    n = sram_pkg::PINS_IDLE;
    n.addr = a;
    n.data = 36'({$urandom(), $urandom()});
    n.chip_n = 1'h0;
    n.expand_n = 1'h0;
    n.expand_hi = 1'h1;
    return n;
  endfunction : sel_pins

  // Applies one cycle of pins and updates the prediction the way the core must decode it.
  task automatic cyc(input sram_pkg::pins_t n);
    logic [3:0]  we;
    logic [16:0] a;
    logic        pl;
    @(negedge clk);
    pins <= n;
    pl = !n.proc_strobe_n && !n.chip_n;
    we = !n.all_lanes_n ? 4'hF : (!n.byte_gate_n ? ~n.lane_write_n : 4'h0);
    if (pl || !n.ctrl_strobe_n) begin
      act = !n.chip_n && !n.expand_n && n.expand_hi;
      base = n.addr;
      cnt = 2'h0;
    end else if (!n.advance_n) begin
      cnt = cnt + 2'h1;
    end
    a = {base[16:2], ilv ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (act && (pl || we == 4'h0)) begin
      exp_q.push_back(mem[a]);
    end else if (act) begin
      for (int i = 0; i < 4; i++) begin
        if (we[i]) mem[a][i*9+:9] = n.data[i*9+:9];
      end
    end
  endtask : cyc

  task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic [3:0] lw, input logic g,
                    input logic al);
    sram_pkg::pins_t n;
    n = sel_pins(a);
    n.ctrl_strobe_n = 1'h0;
    n.data = d;
    n.lane_write_n = lw;
    n.byte_gate_n = g;
    n.all_lanes_n = al;
    cyc(n);
  endtask : wr

  // Write inputs are held active so a processor load that turned into a write would show.
  task automatic rd(input logic [17:0] a);
    sram_pkg::pins_t n;
    n = sel_pins(a);
    n.proc_strobe_n = 1'h0;
    n.all_lanes_n = 1'h0;
    cyc(n);
  endtask : rd

  task automatic step(input logic adv_n);
    sram_pkg::pins_t n;
    n = sel_pins(18'($urandom()));
    n.advance_n = adv_n;
    cyc(n);
  endtask : step

  task automatic desel(input logic [1:0] k);
    sram_pkg::pins_t n;
    n = sel_pins(18'($urandom()));
    n.ctrl_strobe_n = 1'h0;
    n.chip_n = (k == 2'h0);
    n.expand_n = (k == 2'h1);
    n.expand_hi = (k != 2'h2);
    cyc(n);
  endtask : desel
endmodule : sram_host_model

// *** verification/sram_burst_core_tb_top.sv ***
// Self-checking bench for the burst SRAM core: clock, result monitor and scenarios.
`timescale 1ns/1ps
module sram_burst_core_tb_top;
  logic            clk  = 1'h0;
  logic            rst  = 1'h1;
  logic            oe_n = 1'h0;
  logic            ilv  = 1'h0;
  logic            clk_en  = 1'h1;
  logic            en_seen = 1'h1;
  logic [35:0]     dout;
  logic            doe;
  int              fails = 0;
  int              tests_run = 0;
  sram_pkg::pins_t pins;

  initial begin
    forever #4 clk = ~clk;
  end

  sram_host_model host_u (.clk(clk), .ilv(ilv), .pins(pins));

  sram_burst_core #(.NARROW(1'h0)) dut_u (
    .CLK(clk), .RST(rst), .CLK_EN(clk_en), .ADDR(pins.addr), .DATA_IN(pins.data), .DATA_OUT(dout),
    .DATA_OE(doe), .CHIP_EN_N(pins.chip_n), .EXPAND_SELECT_N(pins.expand_n),
    .EXPAND_SELECT_HI(pins.expand_hi), .PROC_ADDR_STROBE_N(pins.proc_strobe_n),
    .CTRL_ADDR_STROBE_N(pins.ctrl_strobe_n), .BURST_ADVANCE_N(pins.advance_n),
    .LANE0_WRITE_N(pins.lane_write_n[0]), .LANE1_WRITE_N(pins.lane_write_n[1]),
    .LANE2_WRITE_N(pins.lane_write_n[2]), .LANE3_WRITE_N(pins.lane_write_n[3]),
    .BYTE_WRITE_GATE_N(pins.byte_gate_n), .ALL_LANES_WRITE_N(pins.all_lanes_n),
    .OUT_EN_N(oe_n), .BURST_INTERLEAVE(ilv));

  // ----------------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    en_seen <= clk_en;
  end

  // Every driven read beat is one result; a beat with nothing noted expects all X and fails unless dout is all X.
  // A frozen edge makes no new beat, so nothing is taken off the queue after it.
  always @(negedge clk) begin
    if (doe === 1'h1 && en_seen) begin
      check(dout, host_u.exp_q.size() > 0 ? host_u.exp_q.pop_front() : 36'hX);
    end
  end

  initial begin
    #80000;
    fails++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    sram_pkg::pins_t n;
    logic [17:0]     a;
    logic [35:0]     held;
    void'($urandom(32'h2F3F));
    repeat (10) @(posedge clk);
    check({35'h0, doe}, 36'h0);
    check(dout, 36'h0);
    @(negedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(18'h0A5C4 + 18'(i), 36'({$urandom(), $urandom()}), 4'($urandom()), 1'($urandom()), 1'h0);
    end
    host_u.desel(2'h0);
    // Linear then interleaved bursts from an odd start, long enough to wrap the group.
    for (int m = 0; m < 2; m++) begin
      ilv = 1'(m);
      host_u.desel(2'h1);
      host_u.desel(2'h2);
      host_u.rd(18'h0A5C5);
      for (int s = 0; s < 5; s++) begin
        host_u.step(s == 1);
      end
      host_u.desel(2'(m));
      // Freeze with read beats still in flight; they must resume where they stopped.
      if (m == 0) begin
        held = dout;
        clk_en <= 1'h0;
        repeat (3) @(negedge clk);
        check(dout, held);
        check({35'h0, doe}, 36'h1);
        clk_en <= 1'h1;
      end
    end
    for (int m = 0; m < 16; m++) begin
      a = 18'h10000 + 18'(m * 4);
      host_u.wr(a, 36'({$urandom(), $urandom()}), 4'hF, 1'h1, 1'h0);
      host_u.wr(a, 36'({$urandom(), $urandom()}), 4'(m), 1'h0, 1'h1);
      host_u.wr(a, 36'({$urandom(), $urandom()}), 4'(m), 1'h1, 1'h1);
      host_u.step(1'h1);
      host_u.step(1'h1);
      if (m == 5) begin
        #3 oe_n = 1'h1;
        #2 check({35'h0, doe}, 36'h0);
        oe_n = 1'h0;
        #1 check({35'h0, doe}, 36'h1);
      end
      host_u.desel(2'(m % 3));
    end
    // A gated processor strobe inside a burst must neither reload nor deselect.
    host_u.rd(18'h0A5C4);
    n = host_u.sel_pins(18'h0A5C4);
    n.proc_strobe_n = 1'h0;
    n.chip_n = 1'h1;
    host_u.cyc(n);
    host_u.step(1'h0);
    host_u.desel(2'h2);
    repeat (3) host_u.step(1'h0);
    check({35'h0, doe}, 36'h0);
    check(36'(host_u.exp_q.size()), 36'h0);
    finish_test();
  end
endmodule : sram_burst_core_tb_top
